// [rtl/cprc_pkg.sv]
package cprc_pkg;

    // Widths of the data path and of the address counter.
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned REV_W = 2;
    localparam int unsigned REV_N = 4;

    // Start address of each stored design revision, index 0 first.
    localparam logic [ADDR_W-1:0] REV_START [REV_N] = '{
        20'h00000,
        20'h40000,
        20'h80000,
        20'hc0000
    };

    // Final address of the stored data; advancing beyond it starts the chain.
    localparam logic [ADDR_W-1:0] LAST_COUNT = 20'hfffff;

    // Values assumed on pins that nobody drives.
    localparam logic REV_PIN_PULL = 1'h1;
    localparam logic EXT_EN_PULL = 1'h1;
    localparam logic BUSY_PULL = 1'h0;

    // Reset values.
    localparam logic [REV_W-1:0] REV_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // Clock of the block, in nanoseconds.
    localparam int unsigned MCLK_PERIOD_NS = 8;

    // Internal oscillator period; half a period rounds up to whole cycles.
    localparam int unsigned OSC_PERIOD_NS = 40;
    localparam int unsigned OSC_HALF_CYC_RAW = (OSC_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 : OSC_HALF_CYC_RAW;
    localparam int unsigned OSC_CNT_W = 4;
    localparam logic [OSC_CNT_W-1:0] OSC_HALF_LAST = OSC_CNT_W'(OSC_HALF_CYC - 1);

    // Length of the internal power-on reset, during which the reset line is held low.
    localparam int unsigned POR_TIME_NS = 1000;
    localparam int unsigned POR_CYC_RAW = (POR_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned POR_CYC = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
    localparam int unsigned POR_CNT_W = 8;
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYC - 1);

    // Number of flip-flops in each pin synchroniser.
    localparam int unsigned SYNC_STAGES = 2;

    // Pin levels after pull resolution, carried together through the synchroniser.
    typedef struct packed {
        logic cs_b;
        logic hold_rst_b;
        logic cfg_pulse_b;
        logic busy;
        logic ext_en;
        logic [REV_W-1:0] rev;
        logic clk_pin;
    } cprc_pins_t;

    localparam int unsigned PINS_W = $bits(cprc_pins_t);

    // Synchroniser reset levels match the idle pins except rev, which resets to 0 against its pull of 1, so no false edge follows reset.
    localparam cprc_pins_t PINS_RESET = '{
        cs_b: 1'h1,
        hold_rst_b: 1'h0,
        cfg_pulse_b: 1'h1,
        busy: 1'h0,
        ext_en: 1'h1,
        rev: 2'h0,
        clk_pin: 1'h0
    };

    // Power-on reset sequencing of the reset line.
    typedef enum logic [0:0] {
        CPRC_POR,
        CPRC_RUN
    } cprc_por_t;

    // Programmed configuration bits.
    typedef struct packed {
        logic osc_src;
        logic fwd_clk_en;
        logic parallel;
        logic decomp;
        logic [REV_W-1:0] rev;
    } cprc_cfg_t;

endpackage

// [rtl/cprc_readout.sv]
`timescale 1ns/100ps
`default_nettype none

module cprc_readout (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Pins from the configured part and the board; busy, the revision enable and the revision pins have a driven flag.
    input wire logic chip_sel_b_i,
    input wire logic hold_reset_b_i,
    input wire logic config_pulse_line_b_i,
    input wire logic busy_i,
    input wire logic busy_driven_i,
    input wire logic pin_revision_choice_enable_i,
    input wire logic pin_revision_choice_enable_driven_i,
    input wire logic revision_pin_lsb_i,
    input wire logic revision_pin_lsb_driven_i,
    input wire logic revision_pin_msb_i,
    input wire logic revision_pin_msb_driven_i,
    input wire logic cfg_clk_pin_i,
    // Programmed configuration bits.
    input wire logic osc_source_sel_i,
    input wire logic fwd_clock_enable_i,
    input wire logic parallel_mode_i,
    input wire logic decompress_enable_i,
    input wire logic [1:0] internal_revision_i,
    // Storage side: word at the current address and its availability.
    input wire logic [cprc_pkg::DATA_W-1:0] store_data_i,
    input wire logic store_ready_i,
    output logic [cprc_pkg::ADDR_W-1:0] store_addr_o,
    // Pins towards the configured part and the next memory.
    output logic [cprc_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic forwarded_config_clock_o,
    output logic forwarded_config_clock_oe_o,
    output logic chain_enable_out_o,
    output logic hold_reset_o,
    output logic hold_reset_oe_o,
    output logic standby_o,
    output logic [1:0] active_revision_o
);

    cprc_pkg::cprc_pins_t pins_raw;
    cprc_pkg::cprc_pins_t pins_s;
    cprc_pkg::cprc_cfg_t cfg;
    logic [cprc_pkg::PINS_W-1:0] sync0_q;
    logic [cprc_pkg::PINS_W-1:0] sync1_q;

    logic [cprc_pkg::OSC_CNT_W-1:0] osc_cnt_q;
    logic osc_q;
    logic src_lvl;
    logic src_prev_q;
    logic src_rise;
    logic src_fall;
    logic cfg_prev_q;
    logic cfg_rise;

    logic [cprc_pkg::ADDR_W-1:0] addr_q;
    logic [cprc_pkg::ADDR_W-1:0] addr_d;
    logic [cprc_pkg::REV_W-1:0] rev_q;
    logic [cprc_pkg::REV_W-1:0] rev_sel;
    logic past_last_q;
    logic busy_eff;
    logic active;
    logic advance;

    cprc_pkg::cprc_por_t por_q;
    logic [cprc_pkg::POR_CNT_W-1:0] por_cnt_q;

    // Undriven pins take their pull value before they are synchronised.
    always_comb begin
        pins_raw.cs_b = chip_sel_b_i;
        pins_raw.hold_rst_b = hold_reset_b_i;
        pins_raw.cfg_pulse_b = config_pulse_line_b_i;
        pins_raw.busy = busy_driven_i ? busy_i : cprc_pkg::BUSY_PULL;
        pins_raw.ext_en = pin_revision_choice_enable_driven_i ?
            pin_revision_choice_enable_i : cprc_pkg::EXT_EN_PULL;
        pins_raw.rev[0] = revision_pin_lsb_driven_i ?
            revision_pin_lsb_i : cprc_pkg::REV_PIN_PULL;
        pins_raw.rev[1] = revision_pin_msb_driven_i ?
            revision_pin_msb_i : cprc_pkg::REV_PIN_PULL;
        pins_raw.clk_pin = cfg_clk_pin_i;
    end

    assign cfg.osc_src = osc_source_sel_i;
    assign cfg.fwd_clk_en = fwd_clock_enable_i;
    assign cfg.parallel = parallel_mode_i;
    assign cfg.decomp = decompress_enable_i;
    assign cfg.rev = internal_revision_i;

    // Two-flop synchroniser on every pin bit; it resets to the idle pin levels, except the revision pins, which reset to 0.
    genvar gi;
    generate
        for (gi = 0; gi < cprc_pkg::PINS_W; gi++) begin : g_sync
            always_ff @(posedge mclk_i) begin
                if (!rst_b_i) begin
                    sync0_q[gi] <= cprc_pkg::PINS_RESET[gi];
                    sync1_q[gi] <= cprc_pkg::PINS_RESET[gi];
                end else begin
                    sync0_q[gi] <= pins_raw[gi];
                    sync1_q[gi] <= sync0_q[gi];
                end
            end
        end
    endgenerate

    assign pins_s = cprc_pkg::cprc_pins_t'(sync1_q);

    // Internal oscillator, a free divider of the block clock.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            osc_cnt_q <= '0;
            osc_q <= 1'h0;
        end else if (osc_cnt_q == cprc_pkg::OSC_HALF_LAST) begin
            osc_cnt_q <= '0;
            osc_q <= ~osc_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 1'h1;
        end
    end

    assign src_lvl = cfg.osc_src ? osc_q : pins_s.clk_pin;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            src_prev_q <= 1'h0;
            cfg_prev_q <= 1'h1;
        end else begin
            src_prev_q <= src_lvl;
            cfg_prev_q <= pins_s.cfg_pulse_b;
        end
    end

    assign src_rise = src_lvl && !src_prev_q;
    assign src_fall = !src_lvl && src_prev_q;
    assign cfg_rise = pins_s.cfg_pulse_b && !cfg_prev_q;

    // Power-on reset: the open-drain reset line is pulled low for a fixed time.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            por_q <= cprc_pkg::CPRC_POR;
            por_cnt_q <= '0;
        end else begin
            unique case (por_q)
                cprc_pkg::CPRC_POR: begin
                    if (por_cnt_q == cprc_pkg::POR_LAST) begin
                        por_q <= cprc_pkg::CPRC_RUN;
                    end else begin
                        por_cnt_q <= por_cnt_q + 1'h1;
                    end
                end
                cprc_pkg::CPRC_RUN: begin
                    por_cnt_q <= por_cnt_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            hold_reset_o <= 1'h0;
            hold_reset_oe_o <= 1'h1;
        end else begin
            hold_reset_o <= 1'h0;
            hold_reset_oe_o <= (por_q == cprc_pkg::CPRC_POR);
        end
    end

    // Revision choice: pins when the enable is low, internal bits otherwise.
    always_comb begin
        if (!pins_s.ext_en) begin
            rev_sel = pins_s.rev;
        end else begin
            rev_sel = cfg.rev;
        end
    end

    assign active = !pins_s.cs_b && pins_s.hold_rst_b;
    // Busy counts only in parallel mode without decompression.
    assign busy_eff = pins_s.busy && cfg.parallel && !cfg.decomp;
    assign advance = src_rise && active && store_ready_i && !busy_eff
        && pins_s.cfg_pulse_b;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rev_q <= cprc_pkg::REV_RESET;
        end else if (cfg_rise) begin
            rev_q <= rev_sel;
        end
    end

    always_comb begin
        addr_d = addr_q;
        if (!active) begin
            addr_d = cprc_pkg::REV_START[rev_q];
        end else if (cfg_rise) begin
            addr_d = cprc_pkg::REV_START[rev_sel];
        end else if (advance) begin
            addr_d = addr_q + 1'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            addr_q <= cprc_pkg::REV_START[cprc_pkg::REV_RESET];
        end else begin
            addr_q <= addr_d;
        end
    end

    // The chain condition stays set until deselect, the reset line going low, a configuration pulse rise or reset clears it.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            past_last_q <= 1'h0;
        end else if (!active || cfg_rise) begin
            past_last_q <= 1'h0;
        end else if (advance && addr_q == cprc_pkg::LAST_COUNT) begin
            past_last_q <= 1'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            chain_enable_out_o <= 1'h1;
        end else begin
            chain_enable_out_o <= !(active && (past_last_q ||
                (advance && addr_q == cprc_pkg::LAST_COUNT)));
        end
    end

    // Data changes on the falling source edge so it is settled at the next rising edge.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            data_o <= cprc_pkg::DATA_RESET;
        end else if (active && src_fall && !busy_eff && store_ready_i) begin
            data_o <= store_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            data_oe_o <= 1'h0;
        end else begin
            data_oe_o <= active;
        end
    end

    // Forwarded clock follows the source, parks high while decompressed data waits.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            forwarded_config_clock_o <= 1'h1;
            forwarded_config_clock_oe_o <= 1'h0;
        end else begin
            forwarded_config_clock_oe_o <= active && cfg.fwd_clk_en;
            if (cfg.decomp && !store_ready_i) begin
                forwarded_config_clock_o <= 1'h1;
            end else begin
                forwarded_config_clock_o <= src_lvl;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            standby_o <= 1'h1;
            store_addr_o <= cprc_pkg::REV_START[cprc_pkg::REV_RESET];
            active_revision_o <= cprc_pkg::REV_RESET;
        end else begin
            standby_o <= pins_s.cs_b;
            store_addr_o <= addr_d;
            active_revision_o <= rev_q;
        end
    end

endmodule

`default_nettype wire

// [tb/cprc_readout_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module cprc_readout_checker (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic chip_sel_b_i,
    input wire logic hold_reset_b_i,
    input wire logic config_pulse_line_b_i,
    input wire logic busy_i,
    input wire logic busy_driven_i,
    input wire logic fwd_clock_enable_i,
    input wire logic parallel_mode_i,
    input wire logic decompress_enable_i,
    input wire logic store_ready_i,
    input wire logic [cprc_pkg::ADDR_W-1:0] store_addr_o,
    input wire logic [cprc_pkg::DATA_W-1:0] data_o,
    input wire logic data_oe_o,
    input wire logic forwarded_config_clock_o,
    input wire logic forwarded_config_clock_oe_o,
    input wire logic chain_enable_out_o,
    input wire logic standby_o,
    input wire logic [1:0] active_revision_o
);
    logic run;
    logic stall;
    logic floated;
    logic [cprc_pkg::ADDR_W-1:0] start;
    assign run = !chip_sel_b_i && hold_reset_b_i && config_pulse_line_b_i;
    assign stall = run && busy_i && busy_driven_i && parallel_mode_i && !decompress_enable_i;
    assign floated = !data_oe_o && !forwarded_config_clock_oe_o;
    assign start = cprc_pkg::REV_START[active_revision_o];
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_chain_needs_run: assert property (!chain_enable_out_o |-> $past(!chip_sel_b_i && hold_reset_b_i, 3))
        else $error("chain enable low while idle");
    a_deselect_standby: assert property (chip_sel_b_i [*3] |=> standby_o && chain_enable_out_o && floated)
        else $error("deselect did not float outputs");
    a_deselect_addr: assert property ((chip_sel_b_i && config_pulse_line_b_i) [*4] |=> store_addr_o == start)
        else $error("deselect did not reset address");
    a_reset_floats: assert property (!hold_reset_b_i [*3] |=> floated && chain_enable_out_o)
        else $error("reset line low did not float outputs");
    a_fwd_needs_enable: assert property (!fwd_clock_enable_i [*3] |=> !forwarded_config_clock_oe_o)
        else $error("forwarded clock driven while disabled");
    a_busy_freeze: assert property (stall [*4] |=> $stable(store_addr_o))
        else $error("address moved while busy");
    a_wait_for_data: assert property ((run && !store_ready_i) [*4] |=> $stable(store_addr_o))
        else $error("address moved without data");
    a_park_high: assert property ((decompress_enable_i && !store_ready_i) [*3] |=> forwarded_config_clock_o)
        else $error("forwarded clock not parked high");
    a_steady_at_rise: assert property ($rose(forwarded_config_clock_o) |-> $stable(data_o))
        else $error("data changed at forwarded clock rise");
    c_stall: cover property (stall [*4]);
    c_standby: cover property ($rose(standby_o));
    c_parked: cover property (decompress_enable_i && !store_ready_i && forwarded_config_clock_o);
endmodule
bind cprc_readout cprc_readout_checker u_chk (.*);
`default_nettype wire

// [tb/cprc_fpga_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cprc_fpga_model (
    input wire logic mclk_i,
    input wire logic hold_i,
    input wire logic stall_i,
    input wire logic hold_reset_oe_i,
    input wire logic fclk_i,
    input wire logic fclk_oe_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i,
    output logic hold_reset_b_o,
    output logic busy_o,
    output logic [7:0] word_o = 8'h00,
    output logic [15:0] rises_o = 16'h0000
);
    logic fclk_q = 1'h1;
    // The reset line is open drain, so it is low while either side pulls it.
    assign hold_reset_b_o = !hold_i && !hold_reset_oe_i;
    assign busy_o = stall_i;
    // A floated data bus reads as the inverse of the last word.
    always @(posedge mclk_i) begin
        fclk_q <= fclk_i;
        if (fclk_oe_i && fclk_i && !fclk_q) begin
            rises_o <= rises_o + 16'h1;
            word_o <= data_oe_i ? data_i : ~word_o;
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define C(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb;
    logic mclk_i = 1'h0, rst_b_i = 1'h0, cs = 1'h1, cf = 1'h1, bd = 1'h1, en = 1'h1, ed = 1'h1, pin = 1'h0;
    logic osc = 1'h0, fen = 1'h1, par = 1'h0, dec = 1'h0, rdy = 1'h1, hold = 1'h0, stall = 1'h0;
    logic doe, fclk, foe, ch, hroe, sby, hrb, busy;
    logic [1:0] rp = 2'h0, rd = 2'h3, ir = 2'h0, ar;
    logic [19:0] ad, a;
    logic [7:0] dat, word, d;
    logic [15:0] rises, r0;
    int failures = 0;
    int samples_checked = 0;
    cprc_readout DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .chip_sel_b_i(cs), .hold_reset_b_i(hrb),
        .config_pulse_line_b_i(cf), .busy_i(busy), .busy_driven_i(bd), .pin_revision_choice_enable_i(en),
        .pin_revision_choice_enable_driven_i(ed), .revision_pin_lsb_i(rp[0]), .revision_pin_lsb_driven_i(rd[0]),
        .revision_pin_msb_i(rp[1]), .revision_pin_msb_driven_i(rd[1]), .cfg_clk_pin_i(pin), .osc_source_sel_i(osc),
        .fwd_clock_enable_i(fen), .parallel_mode_i(par), .decompress_enable_i(dec), .internal_revision_i(ir),
        .store_data_i(ad[7:0] ^ 8'h5a), .store_ready_i(rdy), .store_addr_o(ad), .data_o(dat), .data_oe_o(doe),
        .forwarded_config_clock_o(fclk), .forwarded_config_clock_oe_o(foe), .chain_enable_out_o(ch),
        .hold_reset_o(), .hold_reset_oe_o(hroe), .standby_o(sby), .active_revision_o(ar));
    cprc_fpga_model u_fpga (.mclk_i(mclk_i), .hold_i(hold), .stall_i(stall), .hold_reset_oe_i(hroe), .fclk_i(fclk),
        .fclk_oe_i(foe), .data_i(dat), .data_oe_i(doe), .hold_reset_b_o(hrb), .busy_o(busy), .word_o(word),
        .rises_o(rises));
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic step(input int n);
        repeat (n) begin
            pin <= 1'h1;
            tick(4);
            pin <= 1'h0;
            tick(4);
        end
        tick(4);
    endtask
    task automatic pulse();
        cf <= 1'h0;
        tick(4);
        cf <= 1'h1;
        tick(8);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_reset();
        `C("reset_out", 4'h3, {doe, foe, ch, sby})
        `C("reset_addr", cprc_pkg::REV_START[0], ad)
        rst_b_i <= 1'h1;
        tick(200);
        cs <= 1'h0;
        tick(6);
    endtask
    task automatic t_rev();
        for (int r = 0; r < 4; r++) begin
            {en, rp, ir} <= {1'h0, 2'(r), ~2'(r)};
            pulse();
            `C("pin_rev", 2'(r), ar)
            `C("rev_start", cprc_pkg::REV_START[r], ad)
            {ed, rp, ir} <= {1'h0, ~2'(r), 2'(r)};
            pulse();
            `C("int_rev", 2'(r), ar)
            ed <= 1'h1;
        end
        {en, rd} <= 3'h0;
        pulse();
        `C("undriven_rev", 2'h3, ar)
        {en, rd} <= 3'h7;
    endtask
    task automatic t_adv();
        a = ad;
        r0 = rises;
        step(5);
        `C("advance", a + 20'h5, ad)
        `C("data", (a[7:0] + 8'h5) ^ 8'h5a, dat)
        `C("sampled", (a[7:0] + 8'h4) ^ 8'h5a, word)
        `C("fwd_edges", 16'h5, rises - r0)
        osc <= 1'h1;
        tick(40);
        osc <= 1'h0;
        tick(8);
        `C("osc_source", 1'h1, ad > a + 20'h5)
    endtask
    task automatic t_busy();
        {par, stall} <= 2'h3;
        tick(4);
        {a, d} = {ad, dat};
        step(3);
        `C("busy_hold", {a, d}, {ad, dat})
        stall <= 1'h0;
        step(1);
        `C("after_busy", {a + 20'h1, (a[7:0] + 8'h1) ^ 8'h5a}, {ad, dat})
        for (int k = 0; k < 3; k++) begin
            {par, dec, bd, stall} <= {k != 0, k == 1, k != 2, 1'h1};
            tick(4);
            a = ad;
            step(1);
            `C("busy_ignored", a + 20'h1, ad)
        end
        {par, dec, bd, stall, rdy} <= 5'h4;
        tick(4);
        a = ad;
        step(2);
        `C("not_ready", a, ad)
        dec <= 1'h1;
        tick(6);
        `C("parked", 1'h1, fclk)
        {dec, rdy} <= 2'h1;
        tick(4);
    endtask
    task automatic t_float();
        fen <= 1'h0;
        tick(6);
        `C("fwd_off", 1'h0, foe)
        {fen, hold} <= 2'h3;
        tick(6);
        `C("hold_float", 3'h1, {doe, foe, ch})
        {hold, cs} <= 2'h1;
        tick(6);
        `C("standby", 4'h9, {sby, doe, foe, ch})
        `C("standby_addr", cprc_pkg::REV_START[ar], ad)
    endtask
    initial begin
        tick(5);
        t_reset();
        t_rev();
        t_adv();
        t_busy();
        t_float();
        wrap_up();
    end
    initial begin
        tick(20000);
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
